// [include/mod_defines.vh]
`ifndef MOD_DEFINES_VH
`define MOD_DEFINES_VH

// ==========================================================
// Instruction word layout.
`define MOD_WORD_W 16
`define MOD_OP_W 5
`define MOD_GRP_W 3
`define MOD_DIGIT_W 4

// ==========================================================
// Leading hex digit values.
`define MOD_LD_ZERO 4'h0
`define MOD_LD_STORE_SEC 4'h4
`define MOD_LD_STORE_PRIM 4'h6
`define MOD_LD_PARITY 4'h7
`define MOD_LD_ADD 4'h8
`define MOD_LD_SUB 4'h9
`define MOD_LD_LOAD_PRIM 4'hc
`define MOD_LD_LOAD_SEC 4'he

// ==========================================================
// Second hex digit values under a leading zero.
`define MOD_SD_ENH_STOR 4'h4
`define MOD_SD_FIELD 4'h5
`define MOD_SD_ENH_XFER 4'h7
`define MOD_SD_INTER 4'h8
`define MOD_SD_ENTER_A 4'ha
`define MOD_SD_ENH_REG 4'hb
`define MOD_SD_ENTER_Q 4'hc

// ==========================================================
// Third hex digit values of inter-register transfers.
`define MOD_TD_FROM_Q 4'h9
`define MOD_TD_FROM_A 4'ha

// ==========================================================
// Exact enhanced register codes and bound selectors.
`define MOD_CODE_MICRO 8'h01
`define MOD_CODE_LOAD_SET 8'h02
`define MOD_CODE_STORE_SET 8'h03
`define MOD_BOUND_UPPER 4'h0
`define MOD_BOUND_LOWER 4'h1

// ==========================================================
// Second word high bytes of enhanced storage references.
`define MOD_ESR_LOAD_REG 8'hc0
`define MOD_ESR_STORE_REG 8'hc1
`define MOD_ESR_LOAD_CHAR 8'hc2
`define MOD_ESR_STORE_CHAR 8'hc3

// ==========================================================
// Field reference store selector bit in the first word.
`define MOD_FIELD_STORE_BIT 7

// ==========================================================
// Decoded operation codes.
`define MOD_OP_NONE 5'h00
`define MOD_OP_LOAD_PRIMARY 5'h01
`define MOD_OP_STORE_PRIMARY 5'h02
`define MOD_OP_LOAD_SECONDARY 5'h03
`define MOD_OP_STORE_SECONDARY 5'h04
`define MOD_OP_STORE_PARITY 5'h05
`define MOD_OP_ENTER_PRIMARY 5'h06
`define MOD_OP_ENTER_SECONDARY 5'h07
`define MOD_OP_XFER_PRIMARY 5'h08
`define MOD_OP_XFER_SECONDARY 5'h09
`define MOD_OP_LOAD_SEL_REG 5'h0a
`define MOD_OP_STORE_SEL_REG 5'h0b
`define MOD_OP_LOAD_CHAR 5'h0c
`define MOD_OP_STORE_CHAR 5'h0d
`define MOD_OP_LOAD_FIELD 5'h0e
`define MOD_OP_STORE_FIELD 5'h0f
`define MOD_OP_ENH_XFER 5'h10
`define MOD_OP_LOAD_MICRO 5'h11
`define MOD_OP_LOAD_REGSET 5'h12
`define MOD_OP_STORE_REGSET 5'h13
`define MOD_OP_LOAD_UPPER 5'h14
`define MOD_OP_LOAD_LOWER 5'h15
`define MOD_OP_ADD 5'h16
`define MOD_OP_SUB 5'h17

// ==========================================================
// Instruction groups.
`define MOD_GRP_NONE 3'h0
`define MOD_GRP_STORAGE 3'h1
`define MOD_GRP_REGISTER 3'h2
`define MOD_GRP_INTER 3'h3
`define MOD_GRP_ENH_STOR 3'h4
`define MOD_GRP_ENH_REG 3'h5
`define MOD_GRP_ENH_INTER 3'h6
`define MOD_GRP_FIELD 3'h7

`endif

// [hdl/mod_decoder.v]
// Functional notes
// - Leading digit C loads primary from memory.
// - Leading digit 6 stores primary to memory.
// - Leading digit E loads secondary from memory.
// - Leading digit 4 stores secondary to memory.
// - Leading digit 7 stores primary, parity into primary.
// - Pattern 0A enters operand into primary.
// - Pattern 0C enters operand into secondary.
// - Pattern 08A transfers from primary to destination.
// - Pattern 089 transfers from secondary register.
// - 04 then C0 loads selected register.
// - 04 then C1 stores selected register.
// - 04 then C2 loads character into primary.
// - 04 then C3 stores character from primary.
// - First byte 05 is field reference.
// - Pattern 07 is enhanced register transfer.
// - Exact 0B01 loads the micromemory.
// - Exact 0B02 loads register set.
// - Exact 0B03 stores register set.
// - 0Bx0 loads upper, 0Bx1 lower bound, except exact 0B01.
// - Leading digit 8 adds memory to primary.
// - Leading digit 9 subtracts memory from primary.
`timescale 1ns/1ns
`default_nettype none
`include "mod_defines.vh"

module mod_decoder (
  // Clock and reset.
  input wire i_core_clk,
  input wire i_rst_n,
  // Instruction words from fetch.
  input wire i_word_valid,
  input wire [15:0] i_word,
  output wire o_word_ready,
  // Decoded operation to execution control.
  output reg o_op_valid,
  output reg [4:0] o_op_code,
  output reg [2:0] o_op_group,
  output reg o_unimpl,
  output reg o_two_word,
  output reg [7:0] o_operand,
  output reg [3:0] o_reg_sel,
  output reg [15:0] o_first_word,
  output reg [15:0] o_second_word,
  output reg o_wait_second
);

  // ==========================================================
  // States.
  localparam ST_FIRST = 1'b0;
  localparam ST_SECOND = 1'b1;

  reg state_q;
  reg state_d;
  // First word of a pair, held until its second word arrives.
  reg [15:0] first_q;
  reg [15:0] first_d;

  // Hex digits of the offered word, leading digit first.
  wire [3:0] dig0;
  wire [3:0] dig1;
  wire [3:0] dig2;
  wire [3:0] dig3;
  wire [7:0] low_byte;
  wire [7:0] sec_high;

  assign dig0 = i_word[15:12];
  assign dig1 = i_word[11:8];
  assign dig2 = i_word[7:4];
  assign dig3 = i_word[3:0];
  assign low_byte = i_word[7:0];
  assign sec_high = i_word[15:8];

  // Every word is taken on the cycle it is offered.
  assign o_word_ready = 1'b1;

  // ==========================================================
  // Single word decode.
  reg [4:0] one_op;
  reg [2:0] one_grp;
  reg [7:0] one_operand;
  reg [3:0] one_reg;
  reg one_needs_second;

  always @* begin
    one_op = `MOD_OP_NONE;
    one_grp = `MOD_GRP_NONE;
    one_operand = 8'h00;
    one_reg = 4'h0;
    one_needs_second = 1'b0;
    // Storage references leave the address to the datapath.
    case (dig0)
      `MOD_LD_LOAD_PRIM: begin
        one_op = `MOD_OP_LOAD_PRIMARY;
        one_grp = `MOD_GRP_STORAGE;
      end
      `MOD_LD_STORE_PRIM: begin
        one_op = `MOD_OP_STORE_PRIMARY;
        one_grp = `MOD_GRP_STORAGE;
      end
      `MOD_LD_LOAD_SEC: begin
        one_op = `MOD_OP_LOAD_SECONDARY;
        one_grp = `MOD_GRP_STORAGE;
      end
      `MOD_LD_STORE_SEC: begin
        one_op = `MOD_OP_STORE_SECONDARY;
        one_grp = `MOD_GRP_STORAGE;
      end
      `MOD_LD_PARITY: begin
        one_op = `MOD_OP_STORE_PARITY;
        one_grp = `MOD_GRP_STORAGE;
      end
      `MOD_LD_ADD: begin
        one_op = `MOD_OP_ADD;
        one_grp = `MOD_GRP_STORAGE;
      end
      `MOD_LD_SUB: begin
        one_op = `MOD_OP_SUB;
        one_grp = `MOD_GRP_STORAGE;
      end
      `MOD_LD_ZERO: begin
        case (dig1)
          `MOD_SD_ENTER_A: begin
            one_op = `MOD_OP_ENTER_PRIMARY;
            one_grp = `MOD_GRP_REGISTER;
            one_operand = low_byte;
          end
          `MOD_SD_ENTER_Q: begin
            one_op = `MOD_OP_ENTER_SECONDARY;
            one_grp = `MOD_GRP_REGISTER;
            one_operand = low_byte;
          end
          `MOD_SD_INTER: begin
            case (dig2)
              `MOD_TD_FROM_A: begin
                one_op = `MOD_OP_XFER_PRIMARY;
                one_grp = `MOD_GRP_INTER;
                one_reg = dig3;
              end
              `MOD_TD_FROM_Q: begin
                one_op = `MOD_OP_XFER_SECONDARY;
                one_grp = `MOD_GRP_INTER;
                one_reg = dig3;
              end
              default: begin
                one_op = `MOD_OP_NONE;
              end
            endcase
          end
          `MOD_SD_ENH_STOR: begin
            // The first word of a pair only arms the wait state.
            one_needs_second = 1'b1;
            one_grp = `MOD_GRP_ENH_STOR;
            one_operand = low_byte;
          end
          `MOD_SD_FIELD: begin
            one_grp = `MOD_GRP_FIELD;
            one_operand = low_byte;
            if (i_word[`MOD_FIELD_STORE_BIT]) begin
              one_op = `MOD_OP_STORE_FIELD;
            end else begin
              one_op = `MOD_OP_LOAD_FIELD;
            end
          end
          `MOD_SD_ENH_XFER: begin
            one_op = `MOD_OP_ENH_XFER;
            one_grp = `MOD_GRP_ENH_INTER;
            one_operand = low_byte;
          end
          `MOD_SD_ENH_REG: begin
            one_grp = `MOD_GRP_ENH_REG;
            one_reg = dig2;
            // Exact codes are tested before the bound selectors.
            case (low_byte)
              `MOD_CODE_MICRO: begin
                one_op = `MOD_OP_LOAD_MICRO;
              end
              `MOD_CODE_LOAD_SET: begin
                one_op = `MOD_OP_LOAD_REGSET;
              end
              `MOD_CODE_STORE_SET: begin
                one_op = `MOD_OP_STORE_REGSET;
              end
              default: begin
                if (dig3 == `MOD_BOUND_UPPER) begin
                  one_op = `MOD_OP_LOAD_UPPER;
                end else if (dig3 == `MOD_BOUND_LOWER) begin
                  one_op = `MOD_OP_LOAD_LOWER;
                end else begin
                  one_op = `MOD_OP_NONE;
                end
              end
            endcase
          end
          default: begin
            one_op = `MOD_OP_NONE;
          end
        endcase
      end
      default: begin
        one_op = `MOD_OP_NONE;
      end
    endcase
  end

  // ==========================================================
  // Second word decode of enhanced storage references.
  // Unknown selectors give no operation and raise the flag.
  reg [4:0] two_op;

  always @* begin
    case (sec_high)
      `MOD_ESR_LOAD_REG: begin
        two_op = `MOD_OP_LOAD_SEL_REG;
      end
      `MOD_ESR_STORE_REG: begin
        two_op = `MOD_OP_STORE_SEL_REG;
      end
      `MOD_ESR_LOAD_CHAR: begin
        two_op = `MOD_OP_LOAD_CHAR;
      end
      `MOD_ESR_STORE_CHAR: begin
        two_op = `MOD_OP_STORE_CHAR;
      end
      default: begin
        two_op = `MOD_OP_NONE;
      end
    endcase
  end

  // ==========================================================
  // Sequencing and output selection.
  // Next values of the output registers.
  reg op_valid_d;
  reg [4:0] op_code_d;
  reg [2:0] op_group_d;
  reg unimpl_d;
  reg two_word_d;
  reg [7:0] operand_d;
  reg [3:0] reg_sel_d;
  reg [15:0] first_word_d;
  reg [15:0] second_word_d;

  always @* begin
    state_d = state_q;
    first_d = first_q;
    op_valid_d = 1'b0;
    op_code_d = o_op_code;
    op_group_d = o_op_group;
    unimpl_d = 1'b0;
    two_word_d = o_two_word;
    operand_d = o_operand;
    reg_sel_d = o_reg_sel;
    first_word_d = o_first_word;
    second_word_d = o_second_word;
    case (state_q)
      ST_FIRST: begin
        if (i_word_valid) begin
          if (one_needs_second) begin
            state_d = ST_SECOND;
            first_d = i_word;
          end else begin
            op_valid_d = 1'b1;
            op_code_d = one_op;
            op_group_d = one_grp;
            unimpl_d = (one_op == `MOD_OP_NONE);
            two_word_d = 1'b0;
            operand_d = one_operand;
            reg_sel_d = one_reg;
            first_word_d = i_word;
            second_word_d = 16'h0000;
          end
        end
      end
      ST_SECOND: begin
        // A second word is taken whatever its value.
        if (i_word_valid) begin
          state_d = ST_FIRST;
          op_valid_d = 1'b1;
          op_code_d = two_op;
          op_group_d = `MOD_GRP_ENH_STOR;
          unimpl_d = (two_op == `MOD_OP_NONE);
          two_word_d = 1'b1;
          // The operand stays that of the first word of the pair.
          operand_d = first_q[7:0];
          reg_sel_d = i_word[7:4];
          first_word_d = first_q;
          second_word_d = i_word;
        end
      end
      default: begin
        state_d = ST_FIRST;
      end
    endcase
  end

  // ==========================================================
  // State registers.
  // A reset drops a pending first word, so no stale pair completes.
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_q <= ST_FIRST;
      first_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      first_q <= first_d;
    end
  end

  // ==========================================================
  // Output registers.
  // Outputs other than the pulses and the wait flag hold until the next operation.
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_op_valid <= 1'b0;
      o_op_code <= `MOD_OP_NONE;
      o_op_group <= `MOD_GRP_NONE;
      o_unimpl <= 1'b0;
      o_two_word <= 1'b0;
      o_operand <= 8'h00;
      o_reg_sel <= 4'h0;
      o_first_word <= 16'h0000;
      o_second_word <= 16'h0000;
      o_wait_second <= 1'b0;
    end else begin
      o_op_valid <= op_valid_d;
      o_op_code <= op_code_d;
      o_op_group <= op_group_d;
      o_unimpl <= unimpl_d;
      o_two_word <= two_word_d;
      o_operand <= operand_d;
      o_reg_sel <= reg_sel_d;
      o_first_word <= first_word_d;
      o_second_word <= second_word_d;
      o_wait_second <= (state_d == ST_SECOND);
    end
  end

endmodule

`default_nettype wire

// [dv/mod_decoder_chk.sv]
`timescale 1ns/1ns
`default_nettype none
`include "mod_defines.vh"

// ==========================================================
// Checker on the decoder ports.
module mod_decoder_chk (
  // Clock and reset.
  input wire i_core_clk,
  input wire i_rst_n,
  // Instruction port.
  input wire i_word_valid,
  input wire [15:0] i_word,
  input wire o_word_ready,
  // Decoded operation.
  input wire o_op_valid,
  input wire [4:0] o_op_code,
  input wire [2:0] o_op_group,
  input wire o_unimpl,
  input wire o_two_word,
  input wire [7:0] o_operand,
  input wire [3:0] o_reg_sel,
  input wire [15:0] o_first_word,
  input wire [15:0] o_second_word,
  input wire o_wait_second
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  wire first_w = i_word_valid && !o_wait_second;

  property p_load_prim;
    first_w && i_word[15:12] == 4'hc |=> o_op_valid &&
      o_op_code == `MOD_OP_LOAD_PRIMARY;
  endproperty
  a_load_prim: assert property (p_load_prim)
    else $error("load primary not decoded");
  property p_parity;
    first_w && i_word[15:12] == 4'h7 |=> o_op_code == `MOD_OP_STORE_PARITY;
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity store not decoded");
  property p_enter;
    first_w && i_word[15:8] == 8'h0c |=> o_op_code ==
      `MOD_OP_ENTER_SECONDARY && o_operand == $past(i_word[7:0]);
  endproperty
  a_enter: assert property (p_enter)
    else $error("enter secondary wrong");
  property p_xfer;
    first_w && i_word[15:4] == 12'h08a |=> o_op_code ==
      `MOD_OP_XFER_PRIMARY && o_reg_sel == $past(i_word[3:0]);
  endproperty
  a_xfer: assert property (p_xfer)
    else $error("transfer from primary wrong");
  property p_wait;
    first_w && i_word[15:8] == 8'h04 |=> o_wait_second && !o_op_valid;
  endproperty
  a_wait: assert property (p_wait)
    else $error("first word of pair not held");
  property p_pair;
    o_wait_second && i_word_valid && i_word[15:8] == 8'hc1 |=> o_two_word
      && o_op_code == `MOD_OP_STORE_SEL_REG && o_reg_sel == $past(i_word[7:4]);
  endproperty
  a_pair: assert property (p_pair)
    else $error("store selected register wrong");
  property p_bound;
    first_w && i_word[15:8] == 8'h0b && i_word[7:4] != 4'h0 &&
      i_word[3:0] == 4'h1 |=> o_op_code == `MOD_OP_LOAD_LOWER;
  endproperty
  a_bound: assert property (p_bound)
    else $error("lower bound not decoded");
  property p_sub;
    first_w && i_word[15:12] == 4'h9 |=> o_op_valid &&
      o_op_code == `MOD_OP_SUB && o_op_group == `MOD_GRP_STORAGE;
  endproperty
  a_sub: assert property (p_sub)
    else $error("subtract not decoded");
  property p_idle;
    !i_word_valid |=> !o_op_valid;
  endproperty
  a_idle: assert property (p_idle)
    else $error("operation without a word");
  property p_unimpl;
    o_unimpl |-> o_op_valid && o_op_code == `MOD_OP_NONE;
  endproperty
  a_unimpl: assert property (p_unimpl)
    else $error("unimplemented flag misplaced");
endmodule

bind mod_decoder mod_decoder_chk chk_u (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_word_valid(i_word_valid),
  .i_word(i_word), .o_word_ready(o_word_ready), .o_op_valid(o_op_valid),
  .o_op_code(o_op_code), .o_op_group(o_op_group), .o_unimpl(o_unimpl),
  .o_two_word(o_two_word), .o_operand(o_operand), .o_reg_sel(o_reg_sel),
  .o_first_word(o_first_word), .o_second_word(o_second_word),
  .o_wait_second(o_wait_second)
);
`default_nettype wire

// [dv/mod_fetch_model.sv]
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Fetch unit offering one word per cycle.
module mod_fetch_model (
  // Clock.
  input wire logic i_core_clk,
  // Words toward the decoder.
  output logic o_word_valid,
  output logic [15:0] o_word
);
  initial begin
    o_word_valid = 1'b0;
    o_word = 16'h0000;
  end
  task automatic offer(input logic [15:0] w);
    @(negedge i_core_clk);
    o_word_valid = 1'b1;
    o_word = w;
  endtask
  // A released word line shows the inverse of its last value.
  task automatic rest();
    @(negedge i_core_clk);
    o_word_valid = 1'b0;
    o_word = ~o_word;
  endtask
endmodule
`default_nettype wire

// [dv/test_macro_opcode_decoder_transfers.sv]
`timescale 1ns/1ns
`default_nettype none
`include "mod_defines.vh"

// ==========================================================
// Bench top.
module test_macro_opcode_decoder_transfers;
  logic i_core_clk;
  logic i_rst_n;
  wire vld, rdy, opv, unimpl, two, waits;
  wire [15:0] word, fw, sw;
  wire [4:0] code;
  wire [2:0] grp;
  wire [7:0] opnd;
  wire [3:0] rsel;
  int err_count = 0;
  int num_checks = 0;
  logic [31:0] r;
  logic [15:0] corner [0:22] = '{16'hc123, 16'h6abc, 16'he000,
    16'h4fff, 16'h7001, 16'h8abc, 16'h9fff, 16'h0a5c, 16'h0cff,
    16'h08a3, 16'h0897, 16'h0881, 16'h0b01, 16'h0b02, 16'h0b03,
    16'h0b50, 16'h0b71, 16'h0b72, 16'h0712, 16'h0580, 16'h0501,
    16'h1234, 16'h0000};

  mod_fetch_model fetch_u (.i_core_clk(i_core_clk),
    .o_word_valid(vld), .o_word(word));
  mod_decoder dut_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_word_valid(vld), .i_word(word), .o_word_ready(rdy),
    .o_op_valid(opv), .o_op_code(code), .o_op_group(grp),
    .o_unimpl(unimpl), .o_two_word(two), .o_operand(opnd),
    .o_reg_sel(rsel), .o_first_word(fw), .o_second_word(sw),
    .o_wait_second(waits));

  initial begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end

  task automatic chk(input string name, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ==========================================================
  // Expected group and operation code.
  function automatic logic [7:0] exp_op(input logic [15:0] w, w2);
    logic [7:0] e;
    e = {`MOD_GRP_NONE, `MOD_OP_NONE};
    case (w[15:12])
      4'hc: e = {`MOD_GRP_STORAGE, `MOD_OP_LOAD_PRIMARY};
      4'h6: e = {`MOD_GRP_STORAGE, `MOD_OP_STORE_PRIMARY};
      4'he: e = {`MOD_GRP_STORAGE, `MOD_OP_LOAD_SECONDARY};
      4'h4: e = {`MOD_GRP_STORAGE, `MOD_OP_STORE_SECONDARY};
      4'h7: e = {`MOD_GRP_STORAGE, `MOD_OP_STORE_PARITY};
      4'h8: e = {`MOD_GRP_STORAGE, `MOD_OP_ADD};
      4'h9: e = {`MOD_GRP_STORAGE, `MOD_OP_SUB};
      4'h0: case (w[11:8])
        4'ha: e = {`MOD_GRP_REGISTER, `MOD_OP_ENTER_PRIMARY};
        4'hc: e = {`MOD_GRP_REGISTER, `MOD_OP_ENTER_SECONDARY};
        4'h8: if (w[7:4] == 4'ha)
          e = {`MOD_GRP_INTER, `MOD_OP_XFER_PRIMARY};
        else if (w[7:4] == 4'h9)
          e = {`MOD_GRP_INTER, `MOD_OP_XFER_SECONDARY};
        4'h4: e = {`MOD_GRP_ENH_STOR, (w2[15:10] == 6'h30) ?
          5'h0a + {3'h0, w2[9:8]} : `MOD_OP_NONE};
        4'h5: e = {`MOD_GRP_FIELD, w[7] ? `MOD_OP_STORE_FIELD :
          `MOD_OP_LOAD_FIELD};
        4'h7: e = {`MOD_GRP_ENH_INTER, `MOD_OP_ENH_XFER};
        4'hb: if (w[7:0] == 8'h01)
          e = {`MOD_GRP_ENH_REG, `MOD_OP_LOAD_MICRO};
        else if (w[7:0] == 8'h02)
          e = {`MOD_GRP_ENH_REG, `MOD_OP_LOAD_REGSET};
        else if (w[7:0] == 8'h03)
          e = {`MOD_GRP_ENH_REG, `MOD_OP_STORE_REGSET};
        else if (w[3:1] == 3'h0)
          e = {`MOD_GRP_ENH_REG, 5'h14 + {4'h0, w[0]}};
        else
          e = {`MOD_GRP_ENH_REG, `MOD_OP_NONE};
        default: ;
      endcase
      default: ;
    endcase
    return e;
  endfunction

  // ==========================================================
  // One instruction, with its second word when it is a pair.
  task automatic run(input logic [15:0] w, w2);
    logic [7:0] e;
    logic pair;
    logic [7:0] op;
    logic [3:0] rs;
    e = exp_op(w, w2);
    pair = (w[15:8] == 8'h04);
    op = (w[15:12] == 4'h0 && w[11:8] inside {4'ha, 4'hc, 4'h4, 4'h5,
      4'h7}) ? w[7:0] : 8'h00;
    rs = pair ? w2[7:4] : (w[15:8] == 8'h0b) ? w[7:4] :
      (w[15:4] inside {12'h089, 12'h08a}) ? w[3:0] : 4'h0;
    fetch_u.offer(w);
    if (pair) begin
      @(posedge i_core_clk);
      #1;
      chk("wait", {waits, opv}, 2'b10);
      fetch_u.offer(w2);
    end
    @(posedge i_core_clk);
    #1;
    chk("valid", {opv, rdy, waits}, 3'b110);
    chk("op", {grp, code}, e);
    chk("unimpl", unimpl, e[4:0] == `MOD_OP_NONE);
    chk("two", two, pair);
    chk("words", {fw, sw}, pair ? {w, w2} : {w, 16'h0});
    if (e[4:0] != `MOD_OP_NONE)
      chk("operand", {opnd, rsel}, {op, rs});
  endtask

  // ==========================================================
  // Main sequence and watchdog.
  initial begin
    i_rst_n = 1'b0;
    r = $urandom(32'ha075);
    repeat (12) @(posedge i_core_clk);
    @(negedge i_core_clk);
    i_rst_n = 1'b1;
    foreach (corner[i]) run(corner[i], 16'hc035);
    for (int k = 0; k < 5; k++)
      run(16'h0412 + 16'(k), {(k == 4) ? 8'h55 : 8'hc0 + 8'(k), 8'h7e});
    repeat (300) begin
      r = $urandom;
      run(r[15:0], r[31:16]);
    end
    fetch_u.offer(16'h0433);
    fetch_u.rest();
    i_rst_n = 1'b0;
    @(negedge i_core_clk);
    i_rst_n = 1'b1;
    @(posedge i_core_clk);
    #1;
    chk("wait", waits, 1'b0);
    run(16'h0a11, 16'h0000);
    fetch_u.rest();
    repeat (3) @(posedge i_core_clk);
    results();
  end

  initial begin
    #(8 * 2000 * 4);
    err_count++;
    results();
  end
endmodule
`default_nettype wire
